// file: core/gpio_pullup_pin_select_pkg.sv
// Purpose: Shared constants for the two-port pin function and pull-up block.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes: Each register holds up to 8 bits in the low lane; upper bits read as zero.
// How it works
// (R1) Pull-up bit 1 enables pull-up only while that pin's direction is input.
// (R2) Pull-up bits 7 and 6 read 0; all pull-up bits reset to 0.
// (R3) Pins 7 and 6: direction 0 input; else drive-type picks push-pull or open-drain.
// (R4) Wake-up mode bit forces input on pins 5 to 0; pin 5 also triggers converter.
// (R5) Nonzero timer output select owns port 7 pin 6 function and direction.
// (R6) Port 7 pins 5 and 4 always feed the timer inputs.
// (R7) Port 7 direction is write-only; bits 6 to 4 pick output, reset 0.
// (R8) Port 7 data holds output values for output pins; resets to 0.
// (R9) Port 7 data read gives stored bit if output, pin level if input.
// (R10) Port 7 data bits 7 and 3 to 0 read 1 and ignore writes.
// (R11) Port 5 mode resets 0; bits 7,6 open-drain, bits 5 to 0 wake-up.
// (R12) Port 5 data read gives stored bit if output, pin level if input.
// (R13) Open-drain output pulls low for data 0 and floats for data 1.
package gpio_pullup_pin_select_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_P5_MODE = 8'h00;
    localparam logic [7:0] OFS_P5_DIR = 8'h04;
    localparam logic [7:0] OFS_P5_DATA = 8'h08;
    localparam logic [7:0] OFS_P5_PULLUP = 8'h0C;
    localparam logic [7:0] OFS_P7_DIR = 8'h10;
    localparam logic [7:0] OFS_P7_DATA = 8'h14;

    // Reset values.
    localparam logic [7:0] RST_P5_MODE = 8'h00;
    localparam logic [7:0] RST_P5_DIR = 8'h00;
    localparam logic [7:0] RST_P5_DATA = 8'h00;
    localparam logic [5:0] RST_P5_PULLUP = 6'h00;
    localparam logic [2:0] RST_P7_DIR = 3'h0;
    localparam logic [2:0] RST_P7_DATA = 3'h0;

    // Field positions and fixed read patterns.
    localparam int P7_LO = 4;
    localparam int P7_TIMER_OUT_BIT = 6;
    localparam int P7_TIMER_CLK_BIT = 5;
    localparam int P7_TIMER_RST_BIT = 4;
    localparam int P5_TRIGGER_BIT = 5;
    localparam logic [7:0] P7_DATA_RESERVED_ONES = 8'h8F;
    localparam logic [3:0] TIMER_SELECT_PORT = 4'h0;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: core/gpio_pullup_pin_select.sv
// Purpose: Pin function selection, pull-up control and port registers for an 8-pin and a 3-pin port.
// Assumes: Pin inputs are synchronous to core_clk; the pad resolves levels from the enables.
// Notes: Pin drive outputs are registered, so a register write reaches the pins one cycle later.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module gpio_pullup_pin_select
    import gpio_pullup_pin_select_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Port 5 pins.
    input wire logic [7:0] p5_pin_in,
    output logic [7:0] p5_pin_out,
    output logic [7:0] p5_pin_oe,
    output logic [5:0] p5_pullup_en,
    // Wake-up and converter trigger, active low like the pins.
    output logic [5:0] wakeup_input_n,
    output logic converter_trigger_input_n,
    // Port 7 pins, bits 6 to 4.
    input wire logic [6:4] p7_pin_in,
    output logic [6:4] p7_pin_out,
    output logic [6:4] p7_pin_oe,
    // Timer side.
    input wire logic [3:0] timer_output_select,
    input wire logic timer_output_value,
    output logic timer_clock_input_pin,
    output logic timer_reset_input_pin
);

    // Bus state.
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
    logic [7:0] wr_data_q, wr_data_d;
    logic wr_lane_q, wr_lane_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;
    logic do_write;

    // Register state.
    logic [7:0] p5_mode_q, p5_mode_d, p5_dir_q, p5_dir_d, p5_data_q, p5_data_d;
    logic [5:0] p5_pullup_q, p5_pullup_d;
    logic [6:4] p7_dir_q, p7_dir_d, p7_data_q, p7_data_d;

    // Pin state.
    logic [7:0] p5_out_d, p5_oe_d;
    logic [5:0] pullup_d, wakeup_d;
    logic trigger_d, tclk_d, trst_d;
    logic [6:4] p7_out_d, p7_oe_d;

    // Returns whether an address hits one of the mapped words.
    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = 8'(a);
        addr_known = (b == OFS_P5_MODE) || (b == OFS_P5_DIR) || (b == OFS_P5_DATA) ||
            (b == OFS_P5_PULLUP) || (b == OFS_P7_DIR) || (b == OFS_P7_DATA);
    endfunction

    // Read value of a word; direction registers are write-only and read as zero.
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        logic [7:0] v;
        b = 8'(a);
        v = 8'h00;
        if (b == OFS_P5_MODE) begin
            v = p5_mode_q;
        end else if (b == OFS_P5_DATA) begin
            // (R12) Stored or pin level.
            v = (p5_dir_q & p5_data_q) | (~p5_dir_q & p5_pin_in);
        end else if (b == OFS_P5_PULLUP) begin
            // (R2) Top bits read zero.
            v = {2'b00, p5_pullup_q};
        end else if (b == OFS_P7_DATA) begin
            // (R9) Stored or pin level.
            // (R10) Reserved bits read one.
            v = P7_DATA_RESERVED_ONES;
            v[6:4] = (p7_dir_q & p7_data_q) | (~p7_dir_q & p7_pin_in);
        end
        read_word = {24'h000000, v};
    endfunction

    // Write waits until both address and data are held, so they may arrive in either order.
    always_comb begin
        do_write = aw_held_q && w_held_q && !s_axi_bvalid;
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        wr_lane_d = wr_lane_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            wr_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wr_data_d = s_axi_wdata[7:0];
            wr_lane_d = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = addr_known(wr_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        awready_d = !aw_held_d && !bvalid_d;
        wready_d = !w_held_d && !bvalid_d;
        // One read in flight; the word is sampled at the address handshake.
        rvalid_d = s_axi_rvalid;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        rd_addr_d = rd_addr_q;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rd_addr_d = s_axi_araddr;
            rdata_d = read_word(s_axi_araddr);
            rresp_d = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        arready_d = !rvalid_d;
    end

    // Bus registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= 8'h00;
            wr_lane_q <= 1'b0;
            rd_addr_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            wr_lane_q <= wr_lane_d;
            rd_addr_q <= rd_addr_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
        end
    end

    // Register updates; a cleared low byte strobe leaves every register unchanged.
    always_comb begin
        p5_mode_d = p5_mode_q;
        p5_dir_d = p5_dir_q;
        p5_data_d = p5_data_q;
        p5_pullup_d = p5_pullup_q;
        p7_dir_d = p7_dir_q;
        p7_data_d = p7_data_q;
        if (do_write && wr_lane_q) begin
            if (8'(wr_addr_q) == OFS_P5_MODE) begin
                p5_mode_d = wr_data_q;
            end else if (8'(wr_addr_q) == OFS_P5_DIR) begin
                p5_dir_d = wr_data_q;
            end else if (8'(wr_addr_q) == OFS_P5_DATA) begin
                p5_data_d = wr_data_q;
            end else if (8'(wr_addr_q) == OFS_P5_PULLUP) begin
                p5_pullup_d = wr_data_q[5:0];
            end else if (8'(wr_addr_q) == OFS_P7_DIR) begin
                // (R7) Only bits 6 to 4 stored.
                p7_dir_d = wr_data_q[6:4];
            end else if (8'(wr_addr_q) == OFS_P7_DATA) begin
                // (R10) Reserved bits not stored.
                p7_data_d = wr_data_q[6:4];
            end
        end
    end

    // Register file state; everything comes out of reset cleared.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            // (R11) Mode reset value.
            p5_mode_q <= RST_P5_MODE;
            p5_dir_q <= RST_P5_DIR;
            p5_data_q <= RST_P5_DATA;
            // (R2) Pull-ups reset off.
            p5_pullup_q <= RST_P5_PULLUP;
            p7_dir_q <= RST_P7_DIR;
            // (R8) Data reset value.
            p7_data_q <= RST_P7_DATA;
        end else begin
            p5_mode_q <= p5_mode_d;
            p5_dir_q <= p5_dir_d;
            p5_data_q <= p5_data_d;
            p5_pullup_q <= p5_pullup_d;
            p7_dir_q <= p7_dir_d;
            p7_data_q <= p7_data_d;
        end
    end

    // Pin function decode for both ports.
    always_comb begin
        // (R1) Pull-up gated by input direction.
        pullup_d = p5_pullup_q & ~p5_dir_q[5:0];
        // (R3) Drive type on the two top pins.
        // (R13) Open-drain drives only a low.
        for (int i = 6; i < 8; i++) begin
            p5_oe_d[i] = p5_dir_q[i] && (!p5_mode_q[i] || !p5_data_q[i]);
            p5_out_d[i] = p5_mode_q[i] ? 1'b0 : p5_data_q[i];
        end
        // (R4) Wake-up mode forces input.
        for (int i = 0; i < 6; i++) begin
            p5_oe_d[i] = p5_dir_q[i] && !p5_mode_q[i];
            p5_out_d[i] = p5_data_q[i];
            wakeup_d[i] = p5_mode_q[i] ? p5_pin_in[i] : 1'b1;
        end
        trigger_d = p5_mode_q[P5_TRIGGER_BIT] ? p5_pin_in[P5_TRIGGER_BIT] : 1'b1;
        // (R8) Stored data onto output pins.
        p7_oe_d = p7_dir_q;
        p7_out_d = p7_data_q;
        // (R5) Timer select has priority.
        if (timer_output_select != TIMER_SELECT_PORT) begin
            p7_oe_d[P7_TIMER_OUT_BIT] = 1'b1;
            p7_out_d[P7_TIMER_OUT_BIT] = timer_output_value;
        end
        // (R6) Timer inputs always fed.
        tclk_d = p7_pin_in[P7_TIMER_CLK_BIT];
        trst_d = p7_pin_in[P7_TIMER_RST_BIT];
    end

    // Pin registers; all pins come out of reset as undriven inputs.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            p5_pin_out <= 8'h00;
            p5_pin_oe <= 8'h00;
            p5_pullup_en <= 6'h00;
            wakeup_input_n <= 6'h3F;
            converter_trigger_input_n <= 1'b1;
            p7_pin_out <= 3'h0;
            p7_pin_oe <= 3'h0;
            timer_clock_input_pin <= 1'b0;
            timer_reset_input_pin <= 1'b0;
        end else begin
            p5_pin_out <= p5_out_d;
            p5_pin_oe <= p5_oe_d;
            p5_pullup_en <= pullup_d;
            wakeup_input_n <= wakeup_d;
            converter_trigger_input_n <= trigger_d;
            p7_pin_out <= p7_out_d;
            p7_pin_oe <= p7_oe_d;
            timer_clock_input_pin <= tclk_d;
            timer_reset_input_pin <= trst_d;
        end
    end

    // Checks on pin decode and read-back.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_pullup_gated: assert property ( // (R1)
        !$past(rst) |-> p5_pullup_en == ($past(p5_pullup_q) & ~$past(p5_dir_q[5:0])))
        else $error("pull-up enabled on an output pin");
    chk_pullup_top_zero: assert property ( // (R2)
        (s_axi_rvalid && 8'(rd_addr_q) == OFS_P5_PULLUP) |-> s_axi_rdata[7:6] == 2'b00)
        else $error("pull-up reserved bits not zero");
    chk_drive_type: assert property ( // (R3)
        (!p5_dir_q[7]) |=> !p5_pin_oe[7])
        else $error("top pin driven while direction is input");
    chk_open_drain: assert property ( // (R13)
        (p5_dir_q[6] && p5_mode_q[6]) |=> (p5_pin_out[6] == 1'b0 && p5_pin_oe[6] == !$past(p5_data_q[6])))
        else $error("open-drain pin drives a high");
    chk_wakeup_input: assert property ( // (R4)
        p5_mode_q[3] |=> (!p5_pin_oe[3] && wakeup_input_n[3] == $past(p5_pin_in[3])))
        else $error("wake-up pin not an input");
    chk_timer_priority: assert property ( // (R5)
        (timer_output_select != TIMER_SELECT_PORT) |=> (p7_pin_oe[6] && p7_pin_out[6] == $past(timer_output_value)))
        else $error("timer output lost priority");
    // The first edge after release still shows reset values, so only edges that followed a running cycle count.
    chk_timer_inputs: assert property ( // (R6)
        !$past(rst) |-> (timer_clock_input_pin == $past(p7_pin_in[5]) && timer_reset_input_pin == $past(p7_pin_in[4])))
        else $error("timer input not fed from pin");
    chk_dir_write_only: assert property ( // (R7)
        (s_axi_rvalid && 8'(rd_addr_q) == OFS_P7_DIR) |-> s_axi_rdata == 32'h00000000)
        else $error("write-only direction read back nonzero");
    chk_p7_drive: assert property ( // (R8)
        (timer_output_select == TIMER_SELECT_PORT) |=> (p7_pin_oe == $past(p7_dir_q) && p7_pin_out == $past(p7_data_q)))
        else $error("port 7 pins do not follow registers");
    chk_p7_readback: assert property ( // (R9)
        ($rose(s_axi_rvalid) && 8'(rd_addr_q) == OFS_P7_DATA) |->
        s_axi_rdata[6:4] == (($past(p7_dir_q) & $past(p7_data_q)) | (~$past(p7_dir_q) & $past(p7_pin_in))))
        else $error("port 7 data read-back wrong");
    chk_p7_reserved: assert property ( // (R10)
        (s_axi_rvalid && 8'(rd_addr_q) == OFS_P7_DATA) |-> (s_axi_rdata[7] && s_axi_rdata[3:0] == 4'hF))
        else $error("port 7 reserved bits not one");
    chk_mode_reset: assert property ( // (R11)
        $fell(rst) |-> p5_mode_q == RST_P5_MODE)
        else $error("mode register not cleared by reset");
    chk_p5_readback: assert property ( // (R12)
        ($rose(s_axi_rvalid) && 8'(rd_addr_q) == OFS_P5_DATA) |->
        s_axi_rdata[7:0] == (($past(p5_dir_q) & $past(p5_data_q)) | (~$past(p5_dir_q) & $past(p5_pin_in))))
        else $error("port 5 data read-back wrong");

endmodule

// file: test/pin_world.sv
// Purpose: Far-side model of the pads: resolves each pin level from the block's drive and the board.
// Assumes: The block's output enable wins over the board; on port 5 the board drives where its enable is high, on port 7 always.
// Notes: A released port 5 pin with no pull-up toggles each cycle, so a stale level never passes as good.
`timescale 1ns/1ps
module pin_world (
    // Clock.
    input wire logic core_clk,
    // Block side of the pads.
    input wire logic [7:0] p5_out,
    input wire logic [7:0] p5_oe,
    input wire logic [5:0] p5_pu,
    input wire logic [6:4] p7_out,
    input wire logic [6:4] p7_oe,
    // Board side of the pads.
    input wire logic [7:0] p5_ext,
    input wire logic [7:0] p5_ext_en,
    input wire logic [6:4] p7_ext,
    // Resolved levels.
    output logic [7:0] p5_level,
    output logic [6:4] p7_level
);
    logic float_q = 1'b0;

    // Undriven level alternates so a floating pin never reads steady.
    always @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    // Block drive first, then the board, then a pull-up or the floating pattern.
    assign p5_level = (p5_oe & p5_out) | (~p5_oe & p5_ext_en & p5_ext)
        | (~p5_oe & ~p5_ext_en & ({2'b00, p5_pu} | {8{float_q}}));
    assign p7_level = (p7_oe & p7_out) | (~p7_oe & p7_ext);
endmodule

// file: test/gpio_pullup_pin_select_tb.sv
// Purpose: Self-checking bench for the pin function, pull-up and port register block.
// Assumes: Registers at the byte offsets of the package; pin outputs settle two edges after a write.
// Notes: Each scenario is its own task; the bus tasks wait on the handshakes under a bounded count.
`timescale 1ns/1ps
module gpio_pullup_pin_select_tb;
    import gpio_pullup_pin_select_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [3:0] lane = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, trig_n, tclk, trst;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] p5_in, p5_out, p5_oe;
    logic [7:0] p5_ext = 8'h5A;
    logic [7:0] p5_ext_en = 8'hFF;
    logic [5:0] pu_en, wake_n;
    logic [6:4] p7_in, p7_out, p7_oe;
    logic [6:4] p7_ext = 3'h5;
    logic [3:0] tsel = 4'h0;
    logic tval = 1'b0;
    int n_fail = 0;
    int compares = 0;

    gpio_pullup_pin_select dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .p5_pin_in(p5_in),
        .p5_pin_out(p5_out), .p5_pin_oe(p5_oe), .p5_pullup_en(pu_en), .wakeup_input_n(wake_n),
        .converter_trigger_input_n(trig_n), .p7_pin_in(p7_in), .p7_pin_out(p7_out), .p7_pin_oe(p7_oe),
        .timer_output_select(tsel), .timer_output_value(tval), .timer_clock_input_pin(tclk),
        .timer_reset_input_pin(trst));
    pin_world pads (.core_clk(core_clk), .p5_out(p5_out), .p5_oe(p5_oe), .p5_pu(pu_en), .p7_out(p7_out),
        .p7_oe(p7_oe), .p5_ext(p5_ext), .p5_ext_en(p5_ext_en), .p7_ext(p7_ext), .p5_level(p5_in),
        .p7_level(p7_in));

    // Free-running clock at 125 MHz.
    always #4 core_clk = ~core_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Both write channels offered together; each is dropped on the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        awaddr <= a; wdata <= d; wstrb <= lane; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        check("bvalid", 32'h1, {31'h0, bvalid});
        check("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    // Read data is taken on the same edge that sees rvalid high.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        check("rvalid", 32'h1, {31'h0, rvalid});
        check("rdata", exp & m, rdata & m);
        check("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    // Pin outputs are registered, so two edges cover any write or pad change.
    task automatic settle();
        repeat (2) @(posedge core_clk);
    endtask

    task automatic t_reset();
        rd(OFS_P5_MODE, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_P5_DIR, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_P5_DATA, 32'h5A, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_P5_PULLUP, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_P7_DIR, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_P7_DATA, 32'hDF, 32'hFFFFFFFF, RESP_OKAY);
        rd(8'h18, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wr(8'h18, 32'hFF, RESP_SLVERR);
        // A write with the low byte strobe cleared must leave the register alone.
        lane <= 4'hE;
        wr(OFS_P5_MODE, 32'hFF, RESP_OKAY);
        lane <= 4'hF;
        rd(OFS_P5_MODE, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        check("p5_oe", 32'h0, {24'h0, p5_oe});
        check("p7_oe", 32'h0, {29'h0, p7_oe});
        check("pullup", 32'h0, {26'h0, pu_en});
    endtask

    task automatic t_pullup();
        wr(OFS_P5_PULLUP, 32'hFF, RESP_OKAY);
        rd(OFS_P5_PULLUP, 32'h3F, 32'hFFFFFFFF, RESP_OKAY);
        check("pullup", 32'h3F, {26'h0, pu_en});
        p5_ext_en <= 8'h00;
        settle();
        rd(OFS_P5_DATA, 32'h3F, 32'h3F, RESP_OKAY);
        wr(OFS_P5_DIR, 32'h0F, RESP_OKAY);
        settle();
        check("pullup", 32'h30, {26'h0, pu_en});
        p5_ext_en <= 8'hFF;
        wr(OFS_P5_PULLUP, 32'h00, RESP_OKAY);
    endtask

    task automatic t_drive();
        wr(OFS_P5_DIR, 32'hFF, RESP_OKAY);
        wr(OFS_P5_DATA, 32'hA5, RESP_OKAY);
        settle();
        check("p5_oe", 32'hFF, {24'h0, p5_oe});
        check("p5_out", 32'hA5, {24'h0, p5_out});
        wr(OFS_P5_MODE, 32'hC1, RESP_OKAY);
        settle();
        check("p5_oe", 32'h7E, {24'h0, p5_oe});
        check("p5_out", 32'h25, {24'h0, p5_out});
        rd(OFS_P5_DATA, 32'hA5, 32'hFFFFFFFF, RESP_OKAY);
        wr(OFS_P5_DIR, 32'h3F, RESP_OKAY);
        settle();
        check("p5_oe", 32'h3E, {24'h0, p5_oe});
    endtask

    task automatic t_wakeup();
        wr(OFS_P5_MODE, 32'h3F, RESP_OKAY);
        wr(OFS_P5_DIR, 32'hFF, RESP_OKAY);
        p5_ext <= 8'h15;
        settle();
        check("p5_oe", 32'hC0, {24'h0, p5_oe});
        check("wake_n", 32'h15, {26'h0, wake_n});
        check("trig_n", 32'h0, {31'h0, trig_n});
        wr(OFS_P5_MODE, 32'h00, RESP_OKAY);
        settle();
        check("wake_n", 32'h3F, {26'h0, wake_n});
    endtask

    task automatic t_port7();
        wr(OFS_P7_DIR, 32'h70, RESP_OKAY);
        wr(OFS_P7_DATA, 32'hFF, RESP_OKAY);
        rd(OFS_P7_DATA, 32'hFF, 32'hFFFFFFFF, RESP_OKAY);
        settle();
        check("p7_oe", 32'h7, {29'h0, p7_oe});
        check("p7_out", 32'h7, {29'h0, p7_out});
        wr(OFS_P7_DATA, 32'h00, RESP_OKAY);
        rd(OFS_P7_DATA, 32'h8F, 32'hFFFFFFFF, RESP_OKAY);
        wr(OFS_P7_DIR, 32'h00, RESP_OKAY);
        rd(OFS_P7_DIR, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
        rd(OFS_P7_DATA, 32'hDF, 32'hFFFFFFFF, RESP_OKAY);
    endtask

    task automatic t_timer();
        tsel <= 4'h1;
        tval <= 1'b1;
        p7_ext <= 3'h2;
        settle();
        check("p7_oe", 32'h4, {29'h0, p7_oe});
        check("p7_out6", 32'h1, {31'h0, p7_out[6]});
        check("tclk", 32'h1, {31'h0, tclk});
        check("trst", 32'h0, {31'h0, trst});
        p7_ext <= 3'h1;
        tsel <= 4'h0;
        settle();
        check("trst", 32'h1, {31'h0, trst});
        check("p7_oe", 32'h0, {29'h0, p7_oe});
    endtask

    task automatic conclude();
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Main sequence after 20 cycles of reset.
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_pullup();
        t_drive();
        t_wakeup();
        t_port7();
        t_timer();
        conclude();
    end

    // Watchdog well beyond the roughly 150 cycles that reset and the scenarios need.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        conclude();
    end
endmodule
